/* File: rtl/mpw_pkg.sv */
// Constants for the six-channel pulse-width generator
package mpw_pkg;
  localparam int          NUM_CH       = 6;
  localparam int          DIV_W        = 16;
  localparam int          NUM_PAIRS    = NUM_CH / 2;
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_UPDATE   = 8'h04;
  localparam logic [7:0]  OFF_PAIR     = 8'h08;
  localparam logic [7:0]  OFF_STATUS   = 8'h0c;
  localparam logic [7:0]  OFF_HIGH0    = 8'h10;
  localparam logic [7:0]  OFF_LOW0     = 8'h14;
  localparam logic [7:0]  CH_STRIDE    = 8'h08;
  // Control fields per channel, in CTRL at CH*CTRL_STRIDE
  localparam int          CTRL_STRIDE  = 4;
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CTRL_ONE_BIT = 1;
  localparam int          CTRL_CLK_BIT = 2;
  localparam int          CTRL_IND_BIT = 3;
  // Reset values
  localparam logic [DIV_W-1:0] DIV_RST = 16'h0001;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
endpackage

/* File: rtl/mpw_channel.sv */
// One pulse-width channel: high/low dividers, one-shot, clock select
`timescale 1ns/1ps
module mpw_channel
  import mpw_pkg::*;
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Settings
  input  wire logic             i_en,
  input  wire logic             i_one_shot,
  input  wire logic             i_clk_sel,
  input  wire logic             i_tick_pll,
  input  wire logic             i_tick_xtal,
  input  wire logic [DIV_W-1:0] i_high,
  input  wire logic [DIV_W-1:0] i_low,
  // Status and output
  output logic                  o_done,
  output logic                  o_pwm
);
  typedef struct packed {
    logic             out;
    logic             run;
    logic             done;
    logic [DIV_W-1:0] cnt;
  } mpw_ch_s;
  mpw_ch_s s_q, s_d;
  logic tick;

  // Divide down the chosen input clock
  assign tick = i_clk_sel ? i_tick_xtal : i_tick_pll;

  always_comb begin
    s_d = s_q;
    if (!i_en) begin
      s_d.out  = 1'b0;
      s_d.run  = 1'b0;
      s_d.done = 1'b0;
      s_d.cnt  = '0;
    end else if (!s_q.run && !s_q.done) begin
      s_d.run = 1'b1;
      s_d.out = 1'b1;
      s_d.cnt = i_high;
    end else if (s_q.run && tick) begin
      if (s_q.cnt > DIV_RST) begin
        s_d.cnt = s_q.cnt - DIV_RST;
      end else if (s_q.out) begin
        s_d.out = 1'b0;
        s_d.cnt = i_low;
      end else if (i_one_shot) begin
        s_d.run  = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.out = 1'b1;
        s_d.cnt = i_high;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_pwm  = s_q.out;
  assign o_done = s_q.done;

  AST_OFF_LOW: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_en |=> !o_pwm) else $error("output not low when disabled");
  AST_START_HIGH: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(i_en) |=> o_pwm) else $error("channel did not start high");
  AST_ONESHOT_STOP: assert property (@(posedge i_clk) disable iff (i_rst)
    o_done && i_en |-> !o_pwm) else $error("one-shot still pulsing");
endmodule

/* File: rtl/mpw_top.sv */
// Six-channel pulse-width generator with APB registers
//
// Operation
// - Six independent channels, each own settings
// - Square wave with programmable duty cycle
// - Timing from divided selected input clock
// - Separate 16-bit high and low dividers
// - Update one channel or several together
// - Pair outputs may be mutual inverses
// - Continuous or single-pulse mode per channel
// - Input clock is PLL or crystal
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module mpw_top
  import mpw_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Input clock pins
  input  wire logic              i_pll_clk,
  input  wire logic              i_xtal_clk,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic                   o_pready,
  output logic [31:0]            o_prdata,
  output logic                   o_pslverr,
  // Channel outputs
  output logic [NUM_CH-1:0]      o_pwm
);
  typedef struct packed {
    logic [2:0]                    pll_sy;
    logic [2:0]                    xtal_sy;
    logic                          pll_lv;
    logic                          xtal_lv;
    logic [NUM_CH*CTRL_STRIDE-1:0] ctrl;
    logic [NUM_PAIRS-1:0]          pair_inv;
    logic [NUM_CH-1:0]             upd_hold;
    logic [NUM_CH*DIV_W-1:0]       high_sh;
    logic [NUM_CH*DIV_W-1:0]       low_sh;
    logic [NUM_CH*DIV_W-1:0]       high_act;
    logic [NUM_CH*DIV_W-1:0]       low_act;
    logic [NUM_CH-1:0]             pwm;
    logic                          ready;
    logic [31:0]                   rdata;
    logic                          slverr;
  } mpw_top_s;
  mpw_top_s s_q, s_d;

  logic              tick_pll;
  logic              tick_xtal;
  logic [NUM_CH-1:0] ch_pwm;
  logic [NUM_CH-1:0] ch_done;
  logic              acc;

  // Channel index of a divider register, or NUM_CH if none
  function automatic int div_ch(input logic [7:0] a);
    int r;
    r = NUM_CH;
    for (int c = 0; c < NUM_CH; c++) begin
      if (a == OFF_HIGH0 + 8'(c) * CH_STRIDE || a == OFF_LOW0 + 8'(c) * CH_STRIDE) begin
        r = c;
      end
    end
    return r;
  endfunction

  // Level once the second and third stages agree
  function automatic logic agreed_lvl(input logic [2:0] sy, input logic lv);
    return (sy[1] == sy[2]) ? sy[2] : lv;
  endfunction

  // Rising edges of the filtered input clocks
  assign tick_pll  = agreed_lvl(s_q.pll_sy, s_q.pll_lv) & ~s_q.pll_lv;
  assign tick_xtal = agreed_lvl(s_q.xtal_sy, s_q.xtal_lv) & ~s_q.xtal_lv;
  assign acc       = i_psel & i_penable & ~s_q.ready;

  always_comb begin
    int c;
    logic is_low;
    c         = div_ch(i_paddr);
    is_low    = i_paddr[2];
    s_d       = s_q;
    s_d.pll_sy  = {s_q.pll_sy[1:0], i_pll_clk};
    s_d.xtal_sy = {s_q.xtal_sy[1:0], i_xtal_clk};
    s_d.pll_lv  = agreed_lvl(s_q.pll_sy, s_q.pll_lv);
    s_d.xtal_lv = agreed_lvl(s_q.xtal_sy, s_q.xtal_lv);
    s_d.ready   = acc;
    s_d.slverr  = 1'b0;
    s_d.rdata   = ZERO_WORD;
    // Pending shadow values commit together on an update
    for (int k = 0; k < NUM_CH; k++) begin
      if (s_q.upd_hold[k]) begin
        s_d.high_act[k*DIV_W +: DIV_W] = s_q.high_sh[k*DIV_W +: DIV_W];
        s_d.low_act[k*DIV_W +: DIV_W]  = s_q.low_sh[k*DIV_W +: DIV_W];
      end
    end
    s_d.upd_hold = '0;
    if (acc) begin
      if (i_paddr == OFF_CTRL) begin
        if (i_pwrite) s_d.ctrl = i_pwdata[NUM_CH*CTRL_STRIDE-1:0];
        s_d.rdata = 32'(s_q.ctrl);
      end else if (i_paddr == OFF_UPDATE) begin
        if (i_pwrite) s_d.upd_hold = i_pwdata[NUM_CH-1:0];
      end else if (i_paddr == OFF_PAIR) begin
        if (i_pwrite) s_d.pair_inv = i_pwdata[NUM_PAIRS-1:0];
        s_d.rdata = 32'(s_q.pair_inv);
      end else if (i_paddr == OFF_STATUS) begin
        s_d.rdata = 32'({ch_done, s_q.pwm});
      end else if (c < NUM_CH) begin
        if (i_pwrite) begin
          if (is_low) begin
            s_d.low_sh[c*DIV_W +: DIV_W] = i_pwdata[DIV_W-1:0];
          end else begin
            s_d.high_sh[c*DIV_W +: DIV_W] = i_pwdata[DIV_W-1:0];
          end
          // Independent channel applies at once
          if (!s_q.ctrl[c*CTRL_STRIDE+CTRL_IND_BIT]) begin
            s_d.upd_hold[c] = 1'b1;
          end
        end
        s_d.rdata = is_low ? 32'(s_q.low_sh[c*DIV_W +: DIV_W]) : 32'(s_q.high_sh[c*DIV_W +: DIV_W]);
      end else begin
        s_d.slverr = 1'b1;
      end
    end
    // Inverted pair: odd output follows inverse of even while even channel is enabled
    s_d.pwm = ch_pwm;
    for (int p = 0; p < NUM_PAIRS; p++) begin
      if (s_q.pair_inv[p] && s_q.ctrl[(2*p)*CTRL_STRIDE+CTRL_EN_BIT]) begin
        s_d.pwm[2*p+1] = ~ch_pwm[2*p];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q          <= '0;
      s_q.high_sh  <= {NUM_CH{DIV_RST}};
      s_q.low_sh   <= {NUM_CH{DIV_RST}};
      s_q.high_act <= {NUM_CH{DIV_RST}};
      s_q.low_act  <= {NUM_CH{DIV_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  // Six independent channels
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    mpw_channel u_ch (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_en        (s_q.ctrl[g*CTRL_STRIDE+CTRL_EN_BIT]),
      .i_one_shot  (s_q.ctrl[g*CTRL_STRIDE+CTRL_ONE_BIT]),
      .i_clk_sel   (s_q.ctrl[g*CTRL_STRIDE+CTRL_CLK_BIT]),
      .i_tick_pll  (tick_pll),
      .i_tick_xtal (tick_xtal),
      .i_high      (s_q.high_act[g*DIV_W +: DIV_W]),
      .i_low       (s_q.low_act[g*DIV_W +: DIV_W]),
      .o_done      (ch_done[g]),
      .o_pwm       (ch_pwm[g])
    );
  end

  assign o_pwm     = s_q.pwm;
  assign o_pready  = s_q.ready;
  assign o_prdata  = s_q.rdata;
  assign o_pslverr = s_q.slverr;

  // Bus answer checks
  sequence bad_access;
    acc && div_ch(i_paddr) == NUM_CH && i_paddr != OFF_CTRL && i_paddr != OFF_UPDATE
      && i_paddr != OFF_PAIR && i_paddr != OFF_STATUS;
  endsequence
  AST_APB_READY: assert property (@(posedge i_clk) disable iff (i_rst)
    i_psel && i_penable && !o_pready |=> o_pready) else $error("no ready");
  AST_READY_PULSE: assert property (@(posedge i_clk) disable iff (i_rst)
    o_pready |=> !o_pready) else $error("ready held too long");
  AST_UNMAPPED_ERR: assert property (@(posedge i_clk) disable iff (i_rst)
    bad_access |=> o_pslverr && o_prdata == ZERO_WORD) else $error("unmapped access not refused");

  // Divider commit checks
  sequence upd_write;
    acc && i_pwrite && i_paddr == OFF_UPDATE && i_pwdata[0];
  endsequence
  sequence ind_high0_write;
    acc && i_pwrite && i_paddr == OFF_HIGH0 && !s_q.ctrl[CTRL_IND_BIT];
  endsequence
  sequence grp_high4_write;
    acc && i_pwrite && i_paddr == OFF_HIGH0 + 8'h04 * CH_STRIDE && s_q.ctrl[4*CTRL_STRIDE+CTRL_IND_BIT];
  endsequence
  AST_GROUP_UPDATE: assert property (@(posedge i_clk) disable iff (i_rst)
    upd_write |=> ##1 s_q.high_act[DIV_W-1:0] == $past(s_q.high_sh[DIV_W-1:0]))
    else $error("group update not applied");
  AST_IND_COMMIT: assert property (@(posedge i_clk) disable iff (i_rst)
    ind_high0_write |=> ##1 s_q.high_act[DIV_W-1:0] == $past(i_pwdata[DIV_W-1:0], 2))
    else $error("independent divider write not applied");
  AST_GROUP_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
    grp_high4_write |=> ##1 $stable(s_q.high_act[4*DIV_W +: DIV_W]))
    else $error("grouped divider applied before update");

  // Output path and input clock tick checks
  AST_PAIR_INV: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.pair_inv[0] && s_q.ctrl[CTRL_EN_BIT] |=> o_pwm[1] == ~$past(ch_pwm[0]))
    else $error("pair not inverted");
  AST_PAIR1_INV: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.pair_inv[1] && s_q.ctrl[2*CTRL_STRIDE+CTRL_EN_BIT] |=> o_pwm[3] == ~$past(ch_pwm[2]))
    else $error("second pair not inverted");
  AST_PAIR2_INV: assert property (@(posedge i_clk) disable iff (i_rst)
    s_q.pair_inv[2] && s_q.ctrl[4*CTRL_STRIDE+CTRL_EN_BIT] |=> o_pwm[5] == ~$past(ch_pwm[4]))
    else $error("third pair not inverted");
  AST_PAIR_PLAIN: assert property (@(posedge i_clk) disable iff (i_rst)
    !s_q.pair_inv[0] |=> o_pwm[1] == $past(ch_pwm[1])) else $error("uninverted pair altered");
  AST_FOLLOW: assert property (@(posedge i_clk) disable iff (i_rst)
    !s_q.pair_inv[0] |=> o_pwm[0] == $past(ch_pwm[0])) else $error("output lag wrong");
  AST_TICK_SINGLE: assert property (@(posedge i_clk) disable iff (i_rst)
    tick_pll |=> !tick_pll) else $error("pll tick longer than one cycle");
  AST_XTAL_SINGLE: assert property (@(posedge i_clk) disable iff (i_rst)
    tick_xtal |=> !tick_xtal) else $error("crystal tick longer than one cycle");
endmodule

/* File: sim/mpw_load.sv */
// Load model: measures high and low widths of each output
`timescale 1ns/1ps
module mpw_load
  import mpw_pkg::*;
(
  // Clock
  input  wire logic              i_clk,
  // Driven outputs
  input  wire logic [NUM_CH-1:0] i_pwm,
  // Last widths in clock cycles
  output int                     o_hi_w [NUM_CH],
  output int                     o_lo_w [NUM_CH]
);
  logic [NUM_CH-1:0] last_q = '0;
  int                run_q [NUM_CH];
  always @(posedge i_clk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (i_pwm[c] !== last_q[c]) begin
        if (last_q[c]) o_hi_w[c] <= run_q[c];
        else o_lo_w[c] <= run_q[c];
        run_q[c] <= 1;
      end else begin
        run_q[c] <= run_q[c] + 1;
      end
    end
    last_q <= i_pwm;
  end
endmodule

/* File: sim/tb.sv */
// Bench for the six-channel pulse-width generator
`timescale 1ns/1ps
module tb;
  import mpw_pkg::*;
  logic              i_clk = 1'b0;
  logic              i_rst = 1'b1;
  logic              i_pll_clk = 1'b0;
  logic              i_xtal_clk = 1'b0;
  logic              i_psel = 1'b0;
  logic              i_penable = 1'b0;
  logic              i_pwrite = 1'b0;
  logic [7:0]        i_paddr = 8'h00;
  logic [31:0]       i_pwdata = 32'h0;
  logic              o_pready;
  logic              o_pslverr;
  logic [31:0]       o_prdata;
  logic [NUM_CH-1:0] o_pwm;
  logic [2:0]        cnt = 3'h0;
  logic [31:0]       rd;
  logic              er;
  int                hi_w [NUM_CH];
  int                lo_w [NUM_CH];
  int                fail_count = 0;
  int                n_checks = 0;
  mpw_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_pll_clk(i_pll_clk), .i_xtal_clk(i_xtal_clk),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .o_pwm(o_pwm));
  mpw_load load (.i_clk(i_clk), .i_pwm(o_pwm), .o_hi_w(hi_w), .o_lo_w(lo_w));
  always #4 i_clk = ~i_clk;
  // Input clocks: one pll tick per 4 cycles, one xtal tick per 8
  always @(posedge i_clk) begin
    cnt <= cnt + 3'h1;
    i_pll_clk <= cnt[1];
    i_xtal_clk <= cnt[2];
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (o_pready === 1'b1) break;
    end
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (k == 20) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic set_div(input int ch, input logic [15:0] h, input logic [15:0] l);
    apb(1'b1, OFF_HIGH0 + 8'(ch * 8), {16'h0, h});
    apb(1'b1, OFF_LOW0 + 8'(ch * 8), {16'h0, l});
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    chk("pwm_rst", 32'h0, 32'(o_pwm));
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl_rst", 32'h0, rd);
    apb(1'b0, OFF_HIGH0, 32'h0);
    chk("high0_rst", 32'h1, rd);
    apb(1'b0, 8'h80, 32'h0);
    chk("unmapped_err", 32'h1, 32'(er));
    // ch0 pll, ch2 xtal, ch3 one-shot, ch4 grouped
    apb(1'b1, OFF_CTRL, 32'h0009_3501);
    set_div(0, 16'h0003, 16'h0002);
    set_div(2, 16'h0002, 16'h0002);
    set_div(4, 16'h0005, 16'h0003);
    repeat (120) @(posedge i_clk);
    chk("hi0", 32'd12, hi_w[0]);
    chk("lo0", 32'd8, lo_w[0]);
    chk("hi2", 32'd16, hi_w[2]);
    chk("lo2", 32'd16, lo_w[2]);
    chk("hi4_held", 32'd4, hi_w[4]);
    chk("pwm1_off", 32'h0, 32'(o_pwm[1]));
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("done3", 32'h1, 32'(rd[9]));
    chk("pwm3_stop", 32'h0, 32'(o_pwm[3]));
    apb(1'b1, OFF_UPDATE, 32'h0000_0011);
    repeat (120) @(posedge i_clk);
    chk("hi4_upd", 32'd20, hi_w[4]);
    chk("lo4_upd", 32'd12, lo_w[4]);
    chk("hi0_kept", 32'd12, hi_w[0]);
    apb(1'b1, OFF_PAIR, 32'h0000_0001);
    repeat (3) @(posedge i_clk);
    repeat (24) begin
      @(negedge i_clk);
      chk("pair_inv", {31'h0, ~o_pwm[0]}, 32'(o_pwm[1]));
    end
    apb(1'b1, OFF_CTRL, 32'h0);
    repeat (3) @(posedge i_clk);
    chk("pwm_off", 32'h0, 32'(o_pwm));
    summarize();
  end
endmodule
